// file: system_mode_state_machine.sv
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`include "sysmode_defines.svh"
//Contract
// - Development mode keeps watchdog on; each bad trigger gives one interrupt pulse.
// - Watchdog-off bit in development mode suppresses both interrupt and fail flag on trigger failures.
// - Mask bit in development mode turns the interrupt off; failure then only flags.
// - Regulator short in Init blocks development mode until next power-up.
// - Power-up or soft-reset command in Normal/Stop enters Init, registers reload.
// - Soft reset pulses reset output unless the quiet bit is set.
// - Reset held low below threshold, then delay; later undervoltage means Restart.
// - No undervolt flag while regulator and supply are both low at power-up.
// - Wake events in Init are dropped.
// - Supply undervolt flag updates in Init only after reset output is high.
// - Any bus access in Init with reset high moves to Normal.
// - Bad command content in Init still goes Normal and sets command fail.
// - Normal/Stop change only by command; Stop entry with wake flags interrupts.
// - Sleep command in Stop sets command fail and goes to Restart.
// - Sleep with wake flags pending or no wake source fails to Restart.
// - Faults coinciding with Sleep entry go straight to Restart or Fail-Safe.
// - Reset output drops as soon as Sleep is accepted.
// - Sleep leaves for Restart on any enabled wake or brake short.
// - Restart holds reset low and records entry and causing wakes.
// - Restart goes Normal at reset release; watchdog window and period restart.
// - Fail-Safe exits on wake, thermal release or brake short; fail output latches.
// - Transceiver, bridge and switch faults only flag and interrupt, no mode change.
// - Fail-Safe lasts the filter time; earlier wakes are stored and honoured.
// - In development mode watchdog failures cause no Restart or Fail-Safe.
// - Four consecutive watchdog or undervoltage failures lead to Fail-Safe.
module system_mode_state_machine #(
   parameter int RST_DELAY_CYC   = `RESET_DELAY_MS * (`CLK_HZ / 1000),
   parameter int FS_FILTER_CYC   = `FS_FILTER_MS * (`CLK_HZ / 1000),
   parameter int THERMAL_SHUTDOWN_TWO_FILTER_CYC = `THERMAL_SHUTDOWN_TWO_FILTER_MS * (`CLK_HZ / 1000)
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        main_reg_below_rt,
   input  wire logic        supply_input_uv,
   input  wire logic        main_reg_short_gnd,
   input  wire logic        main_reg_overvolt,
   input  wire logic        thermal_shutdown_two,
   input  wire logic [4:0]  wake_events,
   input  wire logic        brake_short_in,
   input  wire logic [3:0]  fault_events,
   input  wire logic        dev_mode_strap,
   input  wire logic        wd_trigger_fail,
   input  wire logic        wd_trigger_ok,
   output logic             reset_n_out,
   output logic             interrupt_n_out,
   output logic             fail_safe_out,
   output logic             main_reg_enable,
   output logic             wd_enable,
   output logic             wd_open_window_start,
   output logic [3:0]       wd_period,
   output logic             dev_mode_active
);
   localparam int TMR_W    = 26;
   localparam int INT_CYC  = `INT_PULSE_US * (`CLK_HZ / 1000000);
   reg_if rif ();
   sysmode_pkg::sys_mode_e state_q, state_d;
   logic             s_vlow, s_suv, s_short, s_ov, s_tsd, s_brk, s_strap;
   logic [4:0]       s_wake;
   logic [3:0]       s_fault;
   logic [TMR_W-1:0] tmr_q, tsd_tmr_q;
   logic [7:0]       int_cnt_q;
   logic [2:0]       wd_cnt_q, uv_cnt_q;
   logic             rst_out_q, rst_out_d, pwrup_q, sdm_q, sdm_block_q;
   logic             vlow_prev_q, fs_pend_q, fs_tsd_q;
   logic             wd_off_q, irq_mask_q, quiet_q;
   logic [1:0]       ov_sel_q;
   logic [4:0]       wake_en_q, wake_q;
   logic [3:0]       fmask_q, fault_q, wd_period_q;
   logic [6:0]       dstat_q;
   logic             drain_source_overvolt_reg_q;
   function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] off);
      wr_hit = wr && (a == off);
   endfunction : wr_hit
   // Register bus slave
   ahb_reg_slave u_bus (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .bus       (rif)
   );
   // Pin inputs cross into the clock domain
   sync_bank #(.W(16)) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .d       ({main_reg_below_rt, supply_input_uv, main_reg_short_gnd, main_reg_overvolt,
                 thermal_shutdown_two, wake_events, brake_short_in, fault_events, dev_mode_strap}),
      .q       ({s_vlow, s_suv, s_short, s_ov, s_tsd, s_wake, s_brk, s_fault, s_strap})
   );
   // Bus command decode
   logic       acc, cmd_wr, in_init, in_run, in_fs;
   logic [1:0] cmd;
   assign hresp   = 1'b0;
   assign acc     = rif.wr | rif.rd;
   assign cmd_wr  = wr_hit(rif.wr, rif.addr, `OFF_MODE);
   assign cmd     = rif.wdata[1:0];
   assign in_init = (state_q == sysmode_pkg::MODE_INIT);
   assign in_fs   = (state_q == sysmode_pkg::MODE_FAILSAFE);
   assign in_run  = (state_q == sysmode_pkg::MODE_NORMAL) | (state_q == sysmode_pkg::MODE_STOP);
   // Fault causes for mode changes
   logic uv_ev, wd_ev, ov_rs, ov_fs, to_fs, to_rs, flags_any, sleep_bad, rel_ok;
   logic fs_done, tsd_done, fs_wake, sleep_wake;
   assign uv_ev      = s_vlow & ~vlow_prev_q & ~pwrup_q;
   assign wd_ev      = wd_trigger_fail & ~sdm_q;
   assign ov_rs      = s_ov & (ov_sel_q == `OV_RESTART);
   assign ov_fs      = s_ov & (ov_sel_q == `OV_FAILSAFE);
   assign to_fs      = s_tsd | s_short | ov_fs | (wd_ev & (3'(wd_cnt_q + 3'h1) == `FAIL_LIMIT))
                       | (uv_ev & (3'(uv_cnt_q + 3'h1) == `FAIL_LIMIT));
   assign to_rs      = uv_ev | ov_rs | wd_ev;
   assign flags_any  = (|wake_q) | drain_source_overvolt_reg_q;
   assign sleep_bad  = flags_any | ~(|wake_en_q);
   assign rel_ok     = ~s_vlow & (tmr_q >= TMR_W'(RST_DELAY_CYC));
   assign fs_done    = tmr_q >= TMR_W'(FS_FILTER_CYC);
   assign tsd_done   = fs_tsd_q & (tsd_tmr_q >= TMR_W'(THERMAL_SHUTDOWN_TWO_FILTER_CYC));
   assign fs_wake    = (|(s_wake & `FS_WAKE_SRC)) | s_brk;
   assign sleep_wake = (|(s_wake & wake_en_q)) | s_brk;
   // Mode transitions
   always_comb begin
      state_d = state_q;
      case (state_q)
         sysmode_pkg::MODE_INIT: begin
            if (s_short) state_d = sysmode_pkg::MODE_FAILSAFE;
            else if (rst_out_q && acc) state_d = sysmode_pkg::MODE_NORMAL;
         end
         sysmode_pkg::MODE_NORMAL: begin
            if (to_fs) state_d = sysmode_pkg::MODE_FAILSAFE;
            else if (to_rs) state_d = sysmode_pkg::MODE_RESTART;
            else if (cmd_wr) begin
               case (cmd)
                  `CMD_SOFT_RESET: state_d = sysmode_pkg::MODE_INIT;
                  `CMD_STOP:       state_d = sysmode_pkg::MODE_STOP;
                  `CMD_SLEEP:      state_d = sleep_bad ? sysmode_pkg::MODE_RESTART
                                                       : sysmode_pkg::MODE_SLEEP;
                  default:         state_d = state_q;
               endcase
            end
         end
         sysmode_pkg::MODE_STOP: begin
            if (to_fs) state_d = sysmode_pkg::MODE_FAILSAFE;
            else if (to_rs) state_d = sysmode_pkg::MODE_RESTART;
            else if (cmd_wr) begin
               case (cmd)
                  `CMD_SOFT_RESET: state_d = sysmode_pkg::MODE_INIT;
                  `CMD_NORMAL:     state_d = sysmode_pkg::MODE_NORMAL;
                  `CMD_SLEEP:      state_d = sysmode_pkg::MODE_RESTART;
                  default:         state_d = state_q;
               endcase
            end
         end
         sysmode_pkg::MODE_SLEEP: begin
            if (s_tsd || ov_fs) state_d = sysmode_pkg::MODE_FAILSAFE;
            else if (sleep_wake || ov_rs) state_d = sysmode_pkg::MODE_RESTART;
         end
         sysmode_pkg::MODE_RESTART: begin
            if (s_short) state_d = sysmode_pkg::MODE_FAILSAFE;
            else if (rel_ok) state_d = sysmode_pkg::MODE_NORMAL;
         end
         sysmode_pkg::MODE_FAILSAFE: begin
            if (fs_done && (fs_pend_q || fs_wake || tsd_done))
               state_d = sysmode_pkg::MODE_RESTART;
         end
         default: state_d = sysmode_pkg::MODE_INIT;
      endcase
   end
   // Transition strobes
   logic chg, soft_go, enter_fs, enter_rs, leave_fs, stop_in, rs_to_norm;
   assign chg        = (state_d != state_q);
   assign soft_go    = chg & in_run & (state_d == sysmode_pkg::MODE_INIT);
   assign enter_fs   = chg & (state_d == sysmode_pkg::MODE_FAILSAFE);
   assign enter_rs   = chg & (state_d == sysmode_pkg::MODE_RESTART);
   assign leave_fs   = in_fs & chg;
   assign stop_in    = chg & (state_d == sysmode_pkg::MODE_STOP);
   assign rs_to_norm = (state_q == sysmode_pkg::MODE_RESTART) & chg;
   // Reset output level per mode
   always_comb begin
      case (state_d)
         sysmode_pkg::MODE_NORMAL,
         sysmode_pkg::MODE_STOP: rst_out_d = 1'b1;
         sysmode_pkg::MODE_INIT: rst_out_d = soft_go ? quiet_q : (rst_out_q | rel_ok);
         default:                rst_out_d = 1'b0;
      endcase
   end
   // Mode, reset output and timers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q              <= sysmode_pkg::MODE_INIT;
         rst_out_q            <= 1'b0;
         wd_open_window_start <= 1'b0;
         tmr_q                <= '0;
      end else if (clk_en) begin
         state_q              <= state_d;
         rst_out_q            <= rst_out_d;
         wd_open_window_start <= rst_out_d & ~rst_out_q;
         if (chg || (s_vlow && !in_fs)) tmr_q <= '0;
         else if (!(&tmr_q)) tmr_q <= tmr_q + 1'b1;
      end
   end

   // Thermal release filter and stored Fail-Safe wakes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tsd_tmr_q <= '0;
         fs_pend_q <= 1'b0;
         fs_tsd_q  <= 1'b0;
      end else if (clk_en) begin
         tsd_tmr_q <= (s_tsd || !in_fs) ? '0 : ((&tsd_tmr_q) ? tsd_tmr_q : tsd_tmr_q + 1'b1);
         fs_pend_q <= in_fs & ~chg & (fs_pend_q | fs_wake);
         fs_tsd_q  <= enter_fs ? s_tsd : (fs_tsd_q & in_fs);
      end
   end

   // Power-up tracking and development mode latch
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwrup_q     <= 1'b1;
         sdm_q       <= 1'b0;
         sdm_block_q <= 1'b0;
         vlow_prev_q <= 1'b0;
      end else if (clk_en) begin
         vlow_prev_q <= s_vlow;
         if (rst_out_d) pwrup_q <= 1'b0;
         if (in_init && s_short) sdm_block_q <= 1'b1;
         if (in_init && pwrup_q && s_strap && !sdm_block_q && !s_short) sdm_q <= 1'b1;
      end
   end

   // Consecutive failure counters
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wd_cnt_q <= 3'h0;
         uv_cnt_q <= 3'h0;
      end else if (clk_en) begin
         if (enter_fs || wd_trigger_ok) wd_cnt_q <= 3'h0;
         else if (wd_ev && in_run) wd_cnt_q <= 3'(wd_cnt_q + 3'h1);
         if (enter_fs || wd_trigger_ok) uv_cnt_q <= 3'h0;
         else if (uv_ev && in_run) uv_cnt_q <= 3'(uv_cnt_q + 3'h1);
      end
   end

   // Control register writes, soft reset restores defaults
   logic ctl_wr, msk_wr, wdc_wr;
   assign ctl_wr = wr_hit(rif.wr, rif.addr, `OFF_CONTROL);
   assign msk_wr = wr_hit(rif.wr, rif.addr, `OFF_FAULT_MASK);
   assign wdc_wr = wr_hit(rif.wr, rif.addr, `OFF_WATCHDOG_CONTROL_REG);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {wd_off_q, irq_mask_q, quiet_q} <= 3'h0;
         ov_sel_q    <= `OV_SEL_DEF;
         wake_en_q   <= `WAKE_EN_DEF;
         fmask_q     <= `FMASK_DEF;
         wd_period_q <= `WD_PERIOD_DEF;
      end else if (clk_en) begin
         if (soft_go) begin
            {wd_off_q, irq_mask_q, quiet_q} <= 3'h0;
            ov_sel_q  <= `OV_SEL_DEF;
            wake_en_q <= `WAKE_EN_DEF;
            fmask_q   <= `FMASK_DEF;
         end else begin
            if (ctl_wr) begin
               wd_off_q   <= rif.wdata[`CTL_WDOFF];
               irq_mask_q <= rif.wdata[`CTL_IRQMSK];
               quiet_q    <= rif.wdata[`CTL_QUIET];
               ov_sel_q   <= rif.wdata[`CTL_OV_LSB +: 2];
               wake_en_q  <= rif.wdata[`CTL_WKEN_LSB +: 5];
            end
            if (msk_wr) fmask_q <= rif.wdata[3:0];
         end
         if (soft_go || rs_to_norm) wd_period_q <= `WD_PERIOD_DEF;
         else if (wdc_wr) wd_period_q <= rif.wdata[3:0];
      end
   end

   // Sticky status: set wins over write-one-to-clear
   logic [6:0] dstat_set, dstat_clr;
   logic [4:0] wk_en_eff, wk_set, wk_clr;
   logic [3:0] flt_clr;
   logic       drain_source_overvolt_reg_set, drain_source_overvolt_reg_clr, cmd_bad, wd_flag;
   assign cmd_bad   = cmd_wr & ((in_init & (cmd != `CMD_NORMAL))
                      | ((state_q == sysmode_pkg::MODE_STOP) & (cmd == `CMD_SLEEP))
                      | ((state_q == sysmode_pkg::MODE_NORMAL) & (cmd == `CMD_SLEEP) & sleep_bad));
   assign wd_flag   = wd_trigger_fail & in_run & ~(sdm_q & wd_off_q);
   assign dstat_set = {s_suv & (~in_init | rst_out_q),
                       s_ov,
                       s_vlow & ~(pwrup_q & s_suv),
                       cmd_bad,
                       wd_flag,
                       leave_fs,
                       enter_rs};
   assign dstat_clr = {7{wr_hit(rif.wr, rif.addr, `OFF_DEV_STATUS)}} & rif.wdata[6:0];
   assign wk_en_eff = in_init ? 5'h00 : (in_fs ? `FS_WAKE_SRC : wake_en_q);
   assign wk_set    = s_wake & wk_en_eff;
   assign wk_clr    = {5{wr_hit(rif.wr, rif.addr, `OFF_WAKE_STATUS)}} & rif.wdata[4:0];
   assign drain_source_overvolt_reg_set  = s_brk & ~in_init;
   assign drain_source_overvolt_reg_clr  = wr_hit(rif.wr, rif.addr, `OFF_DRAIN_SOURCE_OVERVOLT_REG) & rif.wdata[0];
   assign flt_clr   = {4{wr_hit(rif.wr, rif.addr, `OFF_FAULT_STATUS)}} & rif.wdata[3:0];
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dstat_q <= 7'h00;
         wake_q  <= 5'h00;
         drain_source_overvolt_reg_q  <= 1'b0;
         fault_q <= 4'h0;
      end else if (clk_en) begin
         dstat_q <= soft_go ? 7'h00 : ((dstat_q & ~dstat_clr) | dstat_set);
         wake_q  <= (soft_go || enter_fs) ? 5'h00 : ((wake_q & ~wk_clr) | wk_set);
         drain_source_overvolt_reg_q  <= (soft_go || enter_fs) ? 1'b0 : ((drain_source_overvolt_reg_q & ~drain_source_overvolt_reg_clr) | drain_source_overvolt_reg_set);
         fault_q <= soft_go ? 4'h0 : ((fault_q & ~flt_clr) | s_fault);
      end
   end

   // Interrupt sources stretched into one low pulse
   logic irq_req;
   assign irq_req = (wd_trigger_fail & in_run & sdm_q & ~wd_off_q & ~irq_mask_q)
                    | (|(s_fault & ~fault_q & fmask_q))
                    | (in_run & (|(wk_set & ~wake_q)))
                    | (stop_in & flags_any);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         int_cnt_q <= 8'h00;
      end else if (clk_en) begin
         if (irq_req && int_cnt_q == 8'h00) int_cnt_q <= 8'(INT_CYC);
         else if (int_cnt_q != 8'h00) int_cnt_q <= 8'(int_cnt_q - 8'h01);
      end
   end

   // Register read multiplexer
   assign rif.rdata = (rif.addr == `OFF_MODE)         ? {29'h0, state_q} :
                      (rif.addr == `OFF_CONTROL)      ? {22'h0, wake_en_q, ov_sel_q, quiet_q, irq_mask_q, wd_off_q} :
                      (rif.addr == `OFF_DEV_STATUS)   ? {24'h0, sdm_q, dstat_q} :
                      (rif.addr == `OFF_WAKE_STATUS)  ? {27'h0, wake_q} :
                      (rif.addr == `OFF_DRAIN_SOURCE_OVERVOLT_REG)         ? {31'h0, drain_source_overvolt_reg_q} :
                      (rif.addr == `OFF_FAULT_STATUS) ? {28'h0, fault_q} :
                      (rif.addr == `OFF_FAULT_MASK)   ? {28'h0, fmask_q} :
                      (rif.addr == `OFF_WATCHDOG_CONTROL_REG)      ? {28'h0, wd_period_q} : 32'h0000_0000;

   // Pin outputs
   assign reset_n_out     = rst_out_q;
   assign interrupt_n_out = (int_cnt_q == 8'h00);
   assign fail_safe_out   = in_fs | dstat_q[`ST_FS_ENTERED];
   assign main_reg_enable = ~in_fs & (state_q != sysmode_pkg::MODE_SLEEP);
   assign wd_enable       = in_run & ~(sdm_q & wd_off_q);
   assign wd_period       = wd_period_q;
   assign dev_mode_active = sdm_q;
endmodule : system_mode_state_machine

// file: sysmode_defines.svh
`ifndef SYSMODE_DEFINES_SVH
`define SYSMODE_DEFINES_SVH
// Clock rate and timing figures
`define CLK_HZ            50000000
`define RESET_DELAY_MS    10
`define FS_FILTER_MS      100
`define THERMAL_SHUTDOWN_TWO_FILTER_MS    1000
`define INT_PULSE_US      2
`define FAIL_LIMIT        3'h4
// Mode command field codes
`define CMD_NORMAL        2'h0
`define CMD_SLEEP         2'h1
`define CMD_STOP          2'h2
`define CMD_SOFT_RESET    2'h3
// Overvoltage reaction codes
`define OV_FLAG_ONLY      2'h0
`define OV_RESTART        2'h1
`define OV_FAILSAFE       2'h2
// Register byte offsets
`define OFF_MODE          8'h00
`define OFF_CONTROL       8'h04
`define OFF_DEV_STATUS    8'h08
`define OFF_WAKE_STATUS   8'h0c
`define OFF_DRAIN_SOURCE_OVERVOLT_REG          8'h10
`define OFF_FAULT_STATUS  8'h14
`define OFF_FAULT_MASK    8'h18
`define OFF_WATCHDOG_CONTROL_REG       8'h1c
// Control register fields
`define CTL_WDOFF         0
`define CTL_IRQMSK        1
`define CTL_QUIET         2
`define CTL_OV_LSB        3
`define CTL_WKEN_LSB      5
// Device status fields
`define ST_RESTART        0
`define ST_FS_ENTERED     1
`define ST_WATCHDOG_FAIL_FLAG        2
`define ST_CMD_FAIL       3
`define ST_UV             4
`define ST_OV             5
`define ST_SUPPLY_IN_UNDERVOLT_FLAG       6
// Reset and soft-reset values, fixed Fail-Safe wake sources
`define WAKE_EN_DEF       5'h07
`define FS_WAKE_SRC       5'h07
`define FMASK_DEF         4'hf
`define WD_PERIOD_DEF     4'h4
`define OV_SEL_DEF        2'h1
`endif

// file: sysmode_pkg.sv
package sysmode_pkg;
   typedef enum logic [2:0] {
      MODE_INIT,
      MODE_NORMAL,
      MODE_STOP,
      MODE_SLEEP,
      MODE_RESTART,
      MODE_FAILSAFE
   } sys_mode_e;
endpackage : sysmode_pkg

// file: reg_if.sv
`timescale 1ns/1ns
interface reg_if;
   logic        wr;
   logic        rd;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport bus_side (output wr, output rd, output addr, output wdata, input rdata);
   modport reg_side (input wr, input rd, input addr, input wdata, output rdata);
endinterface : reg_if

// file: sync_bank.sv
`timescale 1ns/1ns
module sync_bank #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   // Two-flop synchroniser per bit
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_q <= 1'b0;
            q[i]   <= 1'b0;
         end else if (clk_en) begin
            meta_q <= d[i];
            q[i]   <= meta_q;
         end
      end
   end
endmodule : sync_bank

// file: ahb_reg_slave.sv
`timescale 1ns/1ns
module ahb_reg_slave (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   reg_if.bus_side          bus
);
   logic       dp1_q;
   logic       wr_q;
   logic [7:0] addr_q;
   logic       take;

   // Address phase accepted on NONSEQ or SEQ
   assign take = hsel & hready & htrans[1];

   // One wait state, then the data phase completes
   assign hreadyout = ~dp1_q;
   assign bus.wr    = dp1_q & wr_q;
   assign bus.rd    = dp1_q & ~wr_q;
   assign bus.addr  = addr_q;
   assign bus.wdata = hwdata;

   // Address phase capture
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dp1_q  <= 1'b0;
         wr_q   <= 1'b0;
         addr_q <= 8'h00;
      end else if (clk_en) begin
         dp1_q <= take;
         if (take) begin
            wr_q   <= hwrite;
            addr_q <= haddr[7:0];
         end
      end
   end

   // Read data registered in the wait cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (clk_en && bus.rd) begin
         hrdata <= bus.rdata;
      end
   end
endmodule : ahb_reg_slave

// file: sysmode_monitor.sv
`timescale 1ns/1ns
module sysmode_monitor (
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       main_reg_below_rt,
   input wire logic       wd_trigger_fail,
   input wire logic       reset_n_out,
   input wire logic       interrupt_n_out,
   input wire logic       main_reg_enable,
   input wire logic       wd_enable,
   input wire logic       wd_open_window_start,
   input wire logic [3:0] wd_period,
   input wire logic       dev_mode_active
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Bus transfer steps
   sequence s_addr; hsel && hready && htrans[1]; endsequence
   sequence s_wait; !hreadyout ##1 hreadyout; endsequence
   // Bus wait, mode, reset and interrupt relations
   a_bus_wait: assert property (s_addr |=> s_wait) else $error("bus wait wrong");
   a_reset_held: assert property (main_reg_below_rt [*6] |-> !reset_n_out) else $error("reset high");
   a_window_start: assert property ($rose(reset_n_out) |-> wd_open_window_start) else $error("no window");
   a_period_default: assert property ($rose(reset_n_out) |-> wd_period == 4'h4) else $error("period");
   a_sleep_reset: assert property (!main_reg_enable |-> !reset_n_out) else $error("reset in sleep");
   a_int_pulse: assert property ($fell(interrupt_n_out) |-> !interrupt_n_out [*8]) else $error("short irq");
   a_dev_no_restart: assert property (dev_mode_active && reset_n_out && wd_trigger_fail
      |=> reset_n_out [*4]) else $error("dev mode restart");
   a_wd_off_quiet: assert property (dev_mode_active && reset_n_out && !wd_enable && wd_trigger_fail
      && interrupt_n_out |=> interrupt_n_out [*3]) else $error("irq with watchdog off");
endmodule : sysmode_monitor

// file: ahb_host_model.sv
`timescale 1ns/1ns
module ahb_host_model (
   input  wire logic        ref_clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [31:0]      hwdata
);
   // Idle bus at time zero
   initial {hsel, haddr, htrans, hwrite, hwdata} = '0;
   // Single word transfer, each phase held until hready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge ref_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hready !== 1'b1);
      r = hrdata;
      hsel <= 1'b0;
      hwdata <= ~d;
   endtask : xfer
endmodule : ahb_host_model

// file: tb_system_mode_state_machine.sv
`timescale 1ns/1ns
module tb_system_mode_state_machine;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
   logic        ref_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, main_reg_below_rt, supply_input_uv;
   logic        dev_mode_strap, main_reg_short_gnd, main_reg_overvolt, thermal_shutdown_two, brake_short_in;
   logic        wd_trigger_fail, wd_trigger_ok, reset_n_out, interrupt_n_out, fail_safe_out, main_reg_enable;
   logic        wd_enable, wd_open_window_start, dev_mode_active, clk_en = 1'b1;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [4:0]  wake_events;
   logic [3:0]  fault_events, wd_period;
   logic [2:0]  hsize = 3'h2;
   logic [1:0]  htrans;
   int          err_total, checks_done;
   row_s        rows [8] = '{'{1'b0, 8'h04, 32'h0, 32'h0e8}, '{1'b1, 8'h1c, 32'h9, 32'h0},
      '{1'b0, 8'h1c, 32'h0, 32'h9}, '{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b1, 8'h00, 32'h2, 32'h0},
      '{1'b0, 8'h00, 32'h0, 32'h2}, '{1'b1, 8'h00, 32'h0, 32'h0}, '{1'b0, 8'h00, 32'h0, 32'h1}};
   assign hready = hreadyout;
   system_mode_state_machine #(.RST_DELAY_CYC(20), .FS_FILTER_CYC(50), .THERMAL_SHUTDOWN_TWO_FILTER_CYC(80)) dut_u (.*);
   ahb_host_model host_u (.*);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : wt
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      host_u.xfer(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask : rd
   // One watchdog failure under a control setting
   task automatic wd_case(input logic [31:0] ctl, input logic i, input logic [31:0] st);
      wr(8'h04, ctl);
      wr(8'h08, 32'h7f);
      wd_trigger_fail <= 1'b1;
      wt(1);
      wd_trigger_fail <= 1'b0;
      wt(3);
      chk({interrupt_n_out, reset_n_out}, {i, 1'b1});
      wt(110);
      rd(8'h08, st);
   endtask : wd_case
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Hang guard
   initial begin
      wt(20000);
      err_total++;
      report_and_stop();
   end
   // Power-up, table rows, then the mode sequences
   initial begin
      {rst_n, main_reg_short_gnd, main_reg_overvolt, thermal_shutdown_two, brake_short_in} = '0;
      {wd_trigger_fail, wd_trigger_ok, wake_events, fault_events} = '0;
      {main_reg_below_rt, supply_input_uv, dev_mode_strap} = 3'h7;
      wt(2);
      rst_n <= 1'b1;
      wt(30);
      chk(reset_n_out, 32'h0);
      main_reg_below_rt <= 1'b0;
      supply_input_uv <= 1'b0;
      wt(30);
      chk(reset_n_out, 32'h1);
      wr(8'h00, 32'h1);
      rd(8'h00, 32'h1);
      rd(8'h08, 32'h88);
      foreach (rows[i]) begin
         host_u.xfer(rows[i].w, rows[i].a, rows[i].d, r);
         if (!rows[i].w) chk(r, rows[i].e);
      end
      wd_case(32'h0e8, 1'b0, 32'h84);
      wd_case(32'h0ea, 1'b1, 32'h84);
      wd_case(32'h0e9, 1'b1, 32'h80);
      wr(8'h04, 32'h0e8);
      wr(8'h00, 32'h2);
      wr(8'h00, 32'h1);
      wt(3);
      chk(reset_n_out, 32'h0);
      wt(40);
      rd(8'h08, 32'h89);
      rd(8'h1c, 32'h4);
      wr(8'h08, 32'h7f);
      wr(8'h00, 32'h1);
      wt(1);
      chk({main_reg_enable, reset_n_out}, 32'h0);
      wake_events <= 5'h01;
      wt(40);
      wake_events <= 5'h00;
      rd(8'h0c, 32'h1);
      rd(8'h08, 32'h81);
      fault_events <= 4'h4;
      wt(8);
      rd(8'h00, 32'h1);
      wr(8'h1c, 32'h9);
      wr(8'h00, 32'h3);
      wt(2);
      chk(reset_n_out, 32'h0);
      wt(40);
      rd(8'h1c, 32'h4);
      chk({hresp, fail_safe_out}, 32'h0);
      thermal_shutdown_two <= 1'b1;
      wt(5);
      thermal_shutdown_two <= 1'b0;
      chk(fail_safe_out, 32'h1);
      wt(150);
      rd(8'h08, 32'h83);
      chk({fail_safe_out, reset_n_out}, 32'h3);
      report_and_stop();
   end
endmodule : tb_system_mode_state_machine
bind system_mode_state_machine sysmode_monitor mon_u (.*);
